// ==== cycle_counter.sv ====
/*
  Down counter that times one instruction's execution.
  Assumes load and decrement never coincide.
*/
`timescale 1ns/100ps
module cycle_counter #(
  parameter int WIDTH = 3
) (
  input  wire logic             clock_in,
  input  wire logic             nrst_in,
  input  wire logic             en_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] value_in,
  input  wire logic             dec_in,
  output logic                  zero_out
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  always_comb
  begin
    count_nxt = count_r;
    if (load_in)
      count_nxt = value_in;
    else if (dec_in && count_r != '0)
      count_nxt = count_r - 1'b1;
  end

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      count_r <= '0;
    else if (en_in)
      count_r <= count_nxt;
  end

  assign zero_out = (count_r == '0);

endmodule

// ==== decode_if.sv ====
/*
  Carrier for decoded fields between the opcode decoder and the top.
  Assumes the decoder is purely combinational.
*/
`timescale 1ns/100ps
interface decode_if;
  import decode_pkg::*;
  logic                legal;
  op_class_e           op;
  logic [CYCLE_W-1:0]  cycles;
  logic                byte_op;
  logic                dest_is_reg;
  logic                sign_ext;
  logic                mem_operand;
  logic                uses_modrm;
  logic [2:0]          imm_bytes;
  logic                writes_result;
  logic [2:0]          short_reg;

  modport producer (output legal, op, cycles, byte_op, dest_is_reg, sign_ext, mem_operand,
                    uses_modrm, imm_bytes, writes_result, short_reg);
  modport consumer (input  legal, op, cycles, byte_op, dest_is_reg, sign_ext, mem_operand,
                    uses_modrm, imm_bytes, writes_result, short_reg);
endinterface

// ==== decode_pkg.sv ====
/*
  Shared constants and types for the subtract, compare and adjust decoder.
  Assumes one core clock; opcode and ModR/M bytes arrive already fetched.
*/
package decode_pkg;

  typedef enum logic [3:0] {
    op_none,
    op_subtract,
    subtract_borrow_op,
    decrement_op,
    compare_op,
    sign_change_op,
    bcd_add_adjust,
    bcd_sub_adjust,
    packed_add_adjust,
    packed_sub_adjust
  } op_class_e;

  localparam int          CYCLE_W = 3;

  // Opcode patterns, matched with casez
  localparam logic [7:0] SUB_RM_OPC       = 8'b001010??;
  localparam logic [7:0] SUB_ACC_OPC      = 8'b0010110?;
  localparam logic [7:0] SBB_RM_OPC       = 8'b000110??;
  localparam logic [7:0] SBB_ACC_OPC      = 8'b0001110?;
  localparam logic [7:0] CMP_RM_OPC       = 8'b001110??;
  localparam logic [7:0] CMP_ACC_OPC      = 8'b0011110?;
  localparam logic [7:0] IMM_GROUP_OPC    = 8'b100000??;
  localparam logic [7:0] INCDEC_GROUP_OPC = 8'b1111111?;
  localparam logic [7:0] DEC_SHORT_OPC    = 8'b01001???;
  localparam logic [7:0] UNARY_GROUP_OPC  = 8'b1111011?;
  localparam logic [7:0] BCD_ADD_OPC      = 8'h37;
  localparam logic [7:0] BCD_SUB_OPC      = 8'h3f;
  localparam logic [7:0] PACKED_ADD_OPC   = 8'h27;
  localparam logic [7:0] PACKED_SUB_OPC   = 8'h2f;

  // Opcode and ModR/M field positions
  localparam int          W_BIT     = 0;
  localparam int          D_BIT     = 1;
  localparam int          S_BIT     = 1;
  localparam int          MOD_HI    = 7;
  localparam int          MOD_LO    = 6;
  localparam int          REGF_HI   = 5;
  localparam int          REGF_LO   = 3;
  localparam logic [1:0]  MOD_REG   = 2'h3;

  // ModR/M reg field selectors
  localparam logic [2:0]  REGF_SUB  = 3'h5;
  localparam logic [2:0]  REGF_SBB  = 3'h3;
  localparam logic [2:0]  REGF_CMP  = 3'h7;
  localparam logic [2:0]  REGF_DEC  = 3'h1;
  localparam logic [2:0]  REGF_NEG  = 3'h3;

  // Execution counts in clocks, identical in every operating mode
  localparam logic [CYCLE_W-1:0] CYC_REG       = 3'h2;
  localparam logic [CYCLE_W-1:0] CYC_SUB_TOREG = 3'h7;
  localparam logic [CYCLE_W-1:0] CYC_SUB_TOMEM = 3'h6;
  localparam logic [CYCLE_W-1:0] CYC_IMM_MEM   = 3'h7;
  localparam logic [CYCLE_W-1:0] CYC_DEC_MEM   = 3'h6;
  localparam logic [CYCLE_W-1:0] CYC_CMP_MEMR  = 3'h5;
  localparam logic [CYCLE_W-1:0] CYC_CMP_RMEM  = 3'h6;
  localparam logic [CYCLE_W-1:0] CYC_CMP_IMEM  = 3'h5;
  localparam logic [CYCLE_W-1:0] CYC_NEG_MEM   = 3'h6;
  localparam logic [CYCLE_W-1:0] CYC_ADJUST    = 3'h4;

  // Immediate byte counts
  localparam logic [2:0]  IMM_NONE  = 3'h0;
  localparam logic [2:0]  IMM_BYTE  = 3'h1;
  localparam logic [2:0]  IMM_WORD  = 3'h2;
  localparam logic [2:0]  IMM_DWORD = 3'h4;

endpackage

// ==== opcode_decode.sv ====
/*
  Combinational decode of one opcode and its ModR/M byte.
  Assumes the ModR/M byte is ignored for forms that carry none.
*/
`timescale 1ns/100ps
module opcode_decode (
  input  wire logic [7:0] opcode_in,
  input  wire logic [7:0] modrm_in,
  input  wire logic       opsize32_in,
  decode_if.producer      dec
);
  import decode_pkg::*;

  logic       reg_direct;
  logic [2:0] regf;
  logic [2:0] full_imm;

  assign reg_direct = (modrm_in[MOD_HI:MOD_LO] == MOD_REG);
  assign regf       = modrm_in[REGF_HI:REGF_LO];
  assign full_imm   = opsize32_in ? IMM_DWORD : IMM_WORD;

  always_comb
  begin
    dec.legal         = 1'b1;
    dec.op            = op_none;
    dec.cycles        = CYC_REG;
    dec.byte_op       = ~opcode_in[W_BIT];
    dec.dest_is_reg   = 1'b0;
    dec.sign_ext      = 1'b0;
    dec.mem_operand   = ~reg_direct;
    dec.uses_modrm    = 1'b1;
    dec.imm_bytes     = IMM_NONE;
    dec.writes_result = 1'b1;
    dec.short_reg     = opcode_in[2:0];
    casez (opcode_in)
      SUB_RM_OPC, SBB_RM_OPC:
      begin
        dec.op          = opcode_in[4] ? subtract_borrow_op : op_subtract;
        dec.dest_is_reg = opcode_in[D_BIT];
        if (!reg_direct)
          dec.cycles = opcode_in[D_BIT] ? CYC_SUB_TOMEM : CYC_SUB_TOREG;
      end
      CMP_RM_OPC:
      begin
        dec.op            = compare_op;
        dec.dest_is_reg   = opcode_in[D_BIT];
        dec.writes_result = 1'b0;
        if (!reg_direct)
          dec.cycles = opcode_in[D_BIT] ? CYC_CMP_RMEM : CYC_CMP_MEMR;
      end
      SUB_ACC_OPC, SBB_ACC_OPC, CMP_ACC_OPC:
      begin
        dec.op            = (opcode_in[5:4] == 2'h3) ? compare_op :
                            (opcode_in[4] ? subtract_borrow_op : op_subtract);
        dec.writes_result = (opcode_in[5:4] != 2'h3);
        dec.uses_modrm    = 1'b0;
        dec.mem_operand   = 1'b0;
        dec.dest_is_reg   = 1'b1;
        dec.imm_bytes     = opcode_in[W_BIT] ? full_imm : IMM_BYTE;
      end
      IMM_GROUP_OPC:
      begin
        // Sign extension only shortens a full-width immediate
        dec.sign_ext  = opcode_in[S_BIT] & opcode_in[W_BIT];
        dec.imm_bytes = (!opcode_in[W_BIT] || opcode_in[S_BIT]) ? IMM_BYTE : full_imm;
        case (regf)
          REGF_SUB:
          begin
            dec.op     = op_subtract;
            dec.cycles = reg_direct ? CYC_REG : CYC_IMM_MEM;
          end
          REGF_SBB:
          begin
            dec.op     = subtract_borrow_op;
            dec.cycles = reg_direct ? CYC_REG : CYC_IMM_MEM;
          end
          REGF_CMP:
          begin
            dec.op            = compare_op;
            dec.writes_result = 1'b0;
            dec.cycles        = reg_direct ? CYC_REG : CYC_CMP_IMEM;
          end
          default: dec.legal = 1'b0;
        endcase
      end
      INCDEC_GROUP_OPC:
      begin
        dec.op     = decrement_op;
        dec.legal  = (regf == REGF_DEC);
        dec.cycles = reg_direct ? CYC_REG : CYC_DEC_MEM;
      end
      DEC_SHORT_OPC:
      begin
        dec.op          = decrement_op;
        dec.uses_modrm  = 1'b0;
        dec.mem_operand = 1'b0;
        dec.dest_is_reg = 1'b1;
        dec.byte_op     = 1'b0;
      end
      UNARY_GROUP_OPC:
      begin
        dec.op     = sign_change_op;
        dec.legal  = (regf == REGF_NEG);
        dec.cycles = reg_direct ? CYC_REG : CYC_NEG_MEM;
      end
      BCD_ADD_OPC, BCD_SUB_OPC, PACKED_ADD_OPC, PACKED_SUB_OPC:
      begin
        dec.op          = opcode_in[4] ? (opcode_in[3] ? bcd_sub_adjust : bcd_add_adjust)
                                       : (opcode_in[3] ? packed_sub_adjust : packed_add_adjust);
        dec.cycles      = CYC_ADJUST;
        dec.uses_modrm  = 1'b0;
        dec.mem_operand = 1'b0;
        dec.byte_op     = 1'b1;
        dec.dest_is_reg = 1'b1;
      end
      default: dec.legal = 1'b0;
    endcase
    if (!dec.legal)
      dec.op = op_none;
  end

endmodule

// ==== sub_cmp_adjust_decode.sv ====
/*
  Decoder and execution timer for subtract, borrow subtract, decrement,
  compare, sign change and the four decimal adjust operations.
  Assumes the fetch unit presents opcode and ModR/M together with a valid
  strobe and holds them until ready is seen high.
*/
// Behaviour
// - Subtract memory forms take seven or six clocks
// - Immediate subtract two or seven; accumulator two
// - Borrow subtract six forms with listed counts
// - Decrement group and short form, two/six
// - Compare register forms two, memory six/five
// - Immediate compare two or five; accumulator two
// - Sign change two register, six memory
// - Unpacked add adjust opcode, four clocks
// - Unpacked subtract adjust opcode, four clocks
// - Packed add adjust opcode, four clocks
// - Packed subtract adjust opcode, four clocks
`timescale 1ns/100ps
module sub_cmp_adjust_decode (
  input  wire logic                        clock_in,
  input  wire logic                        nrst_in,
  input  wire logic                        en_in,
  input  wire logic                        valid_in,
  input  wire logic [7:0]                  opcode_in,
  input  wire logic [7:0]                  modrm_in,
  input  wire logic                        opsize32_in,
  output logic                             ready_out,
  output logic                             busy_out,
  output logic                             done_out,
  output logic                             reject_out,
  output decode_pkg::op_class_e            op_out,
  output logic [decode_pkg::CYCLE_W-1:0]   cycles_out,
  output logic                             byte_op_out,
  output logic                             dest_is_reg_out,
  output logic                             sign_ext_out,
  output logic                             mem_operand_out,
  output logic                             uses_modrm_out,
  output logic [2:0]                       imm_bytes_out,
  output logic                             writes_result_out,
  output logic [2:0]                       short_reg_out
);
  import decode_pkg::*;

  typedef enum logic [0:0] {st_idle, st_exec} state_e;

  decode_if dec ();

  state_e              state_r;
  state_e              state_nxt;
  logic                busy_r;
  logic                busy_nxt;
  logic                done_r;
  logic                done_nxt;
  logic                reject_r;
  logic                reject_nxt;
  logic                ready_r;
  logic                ready_nxt;
  logic                take;
  logic                cnt_zero;
  op_class_e           op_r;
  op_class_e           op_nxt;
  logic [CYCLE_W-1:0]  cycles_r;
  logic [CYCLE_W-1:0]  cycles_nxt;
  logic                byte_op_r;
  logic                byte_op_nxt;
  logic                dest_r;
  logic                dest_nxt;
  logic                sext_r;
  logic                sext_nxt;
  logic                mem_r;
  logic                mem_nxt;
  logic                modrm_r;
  logic                modrm_nxt;
  logic [2:0]          imm_r;
  logic [2:0]          imm_nxt;
  logic                wres_r;
  logic                wres_nxt;
  logic [2:0]          sreg_r;
  logic [2:0]          sreg_nxt;

  opcode_decode u_decode (
    .opcode_in   (opcode_in),
    .modrm_in    (modrm_in),
    .opsize32_in (opsize32_in),
    .dec         (dec)
  );

  // Loaded with count minus one so busy spans exactly the listed clocks
  cycle_counter #(
    .WIDTH (CYCLE_W)
  ) u_counter (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .en_in    (en_in),
    .load_in  (take & dec.legal),
    .value_in (dec.cycles - 1'b1),
    .dec_in   (state_r == st_exec),
    .zero_out (cnt_zero)
  );

  assign take = valid_in & (state_r == st_idle);

  // Control state
  always_comb
  begin
    state_nxt  = state_r;
    busy_nxt   = busy_r;
    done_nxt   = 1'b0;
    reject_nxt = 1'b0;
    case (state_r)
      st_idle:
        if (take)
        begin
          if (dec.legal)
          begin
            state_nxt = st_exec;
            busy_nxt  = 1'b1;
          end
          else
            reject_nxt = 1'b1;
        end
      st_exec:
        if (cnt_zero)
        begin
          state_nxt = st_idle;
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
        end
      default:
      begin
        state_nxt = st_idle;
        busy_nxt  = 1'b0;
      end
    endcase
    ready_nxt = ~busy_nxt;
  end

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r  <= st_idle;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      reject_r <= 1'b0;
      ready_r  <= 1'b1;
    end
    else if (en_in)
    begin
      state_r  <= state_nxt;
      busy_r   <= busy_nxt;
      done_r   <= done_nxt;
      reject_r <= reject_nxt;
      ready_r  <= ready_nxt;
    end
  end

  // Decoded fields, loaded on every take (legal or rejected) and held until the next take
  always_comb
  begin
    op_nxt      = op_r;
    cycles_nxt  = cycles_r;
    byte_op_nxt = byte_op_r;
    dest_nxt    = dest_r;
    sext_nxt    = sext_r;
    mem_nxt     = mem_r;
    modrm_nxt   = modrm_r;
    imm_nxt     = imm_r;
    wres_nxt    = wres_r;
    sreg_nxt    = sreg_r;
    if (take)
    begin
      op_nxt      = dec.op;
      cycles_nxt  = dec.legal ? dec.cycles : '0;
      byte_op_nxt = dec.byte_op;
      dest_nxt    = dec.dest_is_reg;
      sext_nxt    = dec.sign_ext;
      mem_nxt     = dec.mem_operand;
      modrm_nxt   = dec.uses_modrm;
      imm_nxt     = dec.imm_bytes;
      wres_nxt    = dec.writes_result & dec.legal;
      sreg_nxt    = dec.short_reg;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      op_r      <= op_none;
      cycles_r  <= '0;
      byte_op_r <= 1'b0;
      dest_r    <= 1'b0;
      sext_r    <= 1'b0;
      mem_r     <= 1'b0;
      modrm_r   <= 1'b0;
      imm_r     <= IMM_NONE;
      wres_r    <= 1'b0;
      sreg_r    <= 3'h0;
    end
    else if (en_in)
    begin
      op_r      <= op_nxt;
      cycles_r  <= cycles_nxt;
      byte_op_r <= byte_op_nxt;
      dest_r    <= dest_nxt;
      sext_r    <= sext_nxt;
      mem_r     <= mem_nxt;
      modrm_r   <= modrm_nxt;
      imm_r     <= imm_nxt;
      wres_r    <= wres_nxt;
      sreg_r    <= sreg_nxt;
    end
  end

  // Ready has its own flop so no output passes through a gate
  assign ready_out         = ready_r;
  assign busy_out          = busy_r;
  assign done_out          = done_r;
  assign reject_out        = reject_r;
  assign op_out            = op_r;
  assign cycles_out        = cycles_r;
  assign byte_op_out       = byte_op_r;
  assign dest_is_reg_out   = dest_r;
  assign sign_ext_out      = sext_r;
  assign mem_operand_out   = mem_r;
  assign uses_modrm_out    = modrm_r;
  assign imm_bytes_out     = imm_r;
  assign writes_result_out = wres_r;
  assign short_reg_out     = sreg_r;

  a_sub_mem_count: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:1] == 7'b0010100 && modrm_in[7:6] != 2'h3
    |=> cycles_r == 3'h7 && op_r == op_subtract)
    else $error("subtract from memory count wrong");

  a_imm_sub_count: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:2] == 6'b100000 && modrm_in[5:3] == 3'h5
    |=> cycles_r == ($past(modrm_in[7:6]) == 2'h3 ? 3'h2 : 3'h7))
    else $error("immediate subtract count wrong");

  a_borrow_mem_count: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:1] == 7'b0001101 && modrm_in[7:6] != 2'h3
    |=> cycles_r == 3'h6 && op_r == subtract_borrow_op)
    else $error("borrow subtract memory count wrong");

  a_dec_short_form: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:3] == 5'b01001
    |=> op_r == decrement_op && cycles_r == 3'h2 && short_reg_out == $past(opcode_in[2:0]))
    else $error("short decrement decode wrong");

  a_cmp_no_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
    op_r == compare_op |-> !writes_result_out)
    else $error("compare marked as writing a result");

  a_cmp_imm_mem: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:2] == 6'b100000 && modrm_in[5:3] == 3'h7 && modrm_in[7:6] != 2'h3
    |=> cycles_r == 3'h5 && op_r == compare_op)
    else $error("immediate compare memory count wrong");

  a_neg_busy_span: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:1] == 7'b1111011 && modrm_in[5:3] == 3'h3 && modrm_in[7:6] == 2'h3
    ##1 en_in ##1 en_in |-> busy_r && cnt_zero ##0 done_nxt)
    else $error("sign change register timing wrong");

  a_adjust_four: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && (opcode_in == 8'h37 || opcode_in == 8'h3f || opcode_in == 8'h27 || opcode_in == 8'h2f)
    |=> cycles_r == 3'h4 && busy_r)
    else $error("decimal adjust count wrong");

  a_width_bit: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && dec.legal && dec.uses_modrm |=> byte_op_out == !$past(opcode_in[0]))
    else $error("width bit not honoured");

  a_reject_pulse: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && !dec.legal |=> reject_r && !busy_r)
    else $error("unknown opcode not rejected");

  a_borrow_to_reg: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:1] == 7'b0001100 && modrm_in[7:6] != 2'h3
    |=> cycles_r == 3'h7 && op_r == subtract_borrow_op)
    else $error("borrow subtract to register count wrong");

  a_dec_group_mem: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:1] == 7'b1111111 && modrm_in[5:3] == 3'h1 && modrm_in[7:6] != 2'h3
    |=> cycles_r == 3'h6 && op_r == decrement_op)
    else $error("decrement memory count wrong");

  a_cmp_reg_mem: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:1] == 7'b0011101 && modrm_in[7:6] != 2'h3
    |=> cycles_r == 3'h6 && op_r == compare_op)
    else $error("compare register with memory count wrong");

  a_neg_mem_count: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && take && opcode_in[7:1] == 7'b1111011 && modrm_in[5:3] == 3'h3 && modrm_in[7:6] != 2'h3
    |=> cycles_r == 3'h6 && op_r == sign_change_op)
    else $error("sign change memory count wrong");

  a_freeze_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !en_in |=> $stable(busy_r) && $stable(done_r) && $stable(op_r) && $stable(cycles_r))
    else $error("state moved while enable low");

  a_done_one_pulse: assert property (@(posedge clock_in) disable iff (!nrst_in)
    en_in && done_r |=> !done_r)
    else $error("done held longer than one cycle");

endmodule

// ==== tb_sub_cmp_adjust_decode.sv ====
/*
  Self-checking bench for the subtract, compare and adjust decoder.
  Assumes the decoder top and its package are compiled first; one 40 MHz clock.
*/
`timescale 1ns/100ps
module tb_sub_cmp_adjust_decode;
  import decode_pkg::*;

  logic               clock_in;
  logic               nrst_in;
  logic               en_in;
  logic               valid_in;
  logic [7:0]         opcode_in;
  logic [7:0]         modrm_in;
  logic               opsize32_in;
  logic               ready_out;
  logic               busy_out;
  logic               done_out;
  logic               reject_out;
  op_class_e          op_out;
  logic [CYCLE_W-1:0] cycles_out;
  logic               byte_op_out;
  logic               dest_is_reg_out;
  logic               sign_ext_out;
  logic               mem_operand_out;
  logic               uses_modrm_out;
  logic [2:0]         imm_bytes_out;
  logic               writes_result_out;
  logic [2:0]         short_reg_out;
  int                 n_mismatch;
  int                 checks_done;

  sub_cmp_adjust_decode dut (
    .clock_in          (clock_in),
    .nrst_in           (nrst_in),
    .en_in             (en_in),
    .valid_in          (valid_in),
    .opcode_in         (opcode_in),
    .modrm_in          (modrm_in),
    .opsize32_in       (opsize32_in),
    .ready_out         (ready_out),
    .busy_out          (busy_out),
    .done_out          (done_out),
    .reject_out        (reject_out),
    .op_out            (op_out),
    .cycles_out        (cycles_out),
    .byte_op_out       (byte_op_out),
    .dest_is_reg_out   (dest_is_reg_out),
    .sign_ext_out      (sign_ext_out),
    .mem_operand_out   (mem_operand_out),
    .uses_modrm_out    (uses_modrm_out),
    .imm_bytes_out     (imm_bytes_out),
    .writes_result_out (writes_result_out),
    .short_reg_out     (short_reg_out)
  );

  always #12.5 clock_in = ~clock_in;

  task automatic complete_run;
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic present(input logic [7:0] opc, input logic [7:0] mrm, input logic sz);
    @(posedge clock_in);
    valid_in    <= 1'b1;
    opcode_in   <= opc;
    modrm_in    <= mrm;
    opsize32_in <= sz;
  endtask

  // Request is taken at this edge; valid drops right after it
  task automatic take;
    @(posedge clock_in);
    valid_in <= 1'b0;
  endtask

  // Counts busy cycles; ends at the sample where busy has fallen
  task automatic finish_exec(output int n);
    n = 0;
    @(negedge clock_in);
    while (busy_out === 1'b1 && n < 20)
    begin
      n++;
      @(negedge clock_in);
    end
    if (n >= 20)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic run_case(input logic [7:0] opc, input logic [7:0] mrm, input op_class_e op, input int cyc);
    int n;
    present(opc, mrm, 1'b1);
    take();
    finish_exec(n);
    chk("op_out", {4'h0, op}, {4'h0, op_out});
    chk("cycles_out", cyc[7:0], {5'h0, cycles_out});
    chk("busy_length", cyc[7:0], n[7:0]);
    chk("done_out", 8'h01, {7'h0, done_out});
    chk("ready_out", 8'h01, {7'h0, ready_out});
    chk("writes_result", {7'h0, op != compare_op}, {7'h0, writes_result_out});
    @(negedge clock_in);
    chk("done_pulse", 8'h00, {7'h0, done_out});
  endtask

  task automatic run_reject(input logic [7:0] opc, input logic [7:0] mrm);
    present(opc, mrm, 1'b1);
    take();
    @(negedge clock_in);
    chk("reject_out", 8'h01, {7'h0, reject_out});
    chk("busy_out", 8'h00, {7'h0, busy_out});
    chk("op_out", {4'h0, op_none}, {4'h0, op_out});
    chk("cycles_out", 8'h00, {5'h0, cycles_out});
    @(negedge clock_in);
    chk("reject_pulse", 8'h00, {7'h0, reject_out});
  endtask

  // Expected {byte_op, sign_ext, mem_operand, uses_modrm, imm_bytes}
  task automatic field_case(input logic [7:0] opc, input logic [7:0] mrm, input logic sz, input logic [7:0] exp);
    int n;
    present(opc, mrm, sz);
    take();
    finish_exec(n);
    chk("fields", exp, {1'b0, byte_op_out, sign_ext_out, mem_operand_out, uses_modrm_out, imm_bytes_out});
  endtask

  task automatic sc_subtract;
    run_case(8'h28, 8'h06, op_subtract, 7);
    run_case(8'h2b, 8'h06, op_subtract, 6);
    run_case(8'h29, 8'hc1, op_subtract, 2);
    run_case(8'h80, 8'he8, op_subtract, 2);
    run_case(8'h81, 8'h2e, op_subtract, 7);
    run_case(8'h2c, 8'h00, op_subtract, 2);
    run_case(8'h2d, 8'h00, op_subtract, 2);
  endtask

  task automatic sc_borrow;
    run_case(8'h1a, 8'hc0, subtract_borrow_op, 2);
    run_case(8'h18, 8'h46, subtract_borrow_op, 7);
    run_case(8'h1b, 8'h06, subtract_borrow_op, 6);
    run_case(8'h83, 8'hd8, subtract_borrow_op, 2);
    run_case(8'h83, 8'h1e, subtract_borrow_op, 7);
    run_case(8'h1c, 8'h00, subtract_borrow_op, 2);
  endtask

  task automatic sc_dec_cmp_neg;
    run_case(8'hfe, 8'hc8, decrement_op, 2);
    run_case(8'hff, 8'h0e, decrement_op, 6);
    run_case(8'h4b, 8'h00, decrement_op, 2);
    run_case(8'h38, 8'hc0, compare_op, 2);
    run_case(8'h38, 8'h06, compare_op, 5);
    run_case(8'h3b, 8'h86, compare_op, 6);
    run_case(8'h80, 8'hf8, compare_op, 2);
    run_case(8'h81, 8'h3e, compare_op, 5);
    run_case(8'h3d, 8'h00, compare_op, 2);
    run_case(8'hf6, 8'hd8, sign_change_op, 2);
    run_case(8'hf7, 8'h1e, sign_change_op, 6);
  endtask

  task automatic sc_adjust;
    run_case(8'h37, 8'h00, bcd_add_adjust, 4);
    run_case(8'h3f, 8'h00, bcd_sub_adjust, 4);
    run_case(8'h27, 8'h00, packed_add_adjust, 4);
    run_case(8'h2f, 8'h00, packed_sub_adjust, 4);
  endtask

  // Neighbouring reg fields and opcode 00 belong to other blocks
  task automatic sc_reject;
    run_reject(8'h80, 8'hc0);
    run_reject(8'hfe, 8'hc0);
    run_reject(8'hf6, 8'he0);
    run_reject(8'h00, 8'h00);
  endtask

  task automatic sc_fields;
    field_case(8'h81, 8'h2e, 1'b1, 8'h1c);
    field_case(8'h81, 8'h2e, 1'b0, 8'h1a);
    field_case(8'h80, 8'he8, 1'b1, 8'h49);
    field_case(8'h83, 8'he8, 1'b1, 8'h29);
    field_case(8'h2a, 8'h06, 1'b1, 8'h58);
    chk("dest_is_reg", 8'h01, {7'h0, dest_is_reg_out});
    field_case(8'h28, 8'hc1, 1'b0, 8'h48);
    chk("dest_is_reg", 8'h00, {7'h0, dest_is_reg_out});
    field_case(8'h4b, 8'h00, 1'b1, 8'h00);
    chk("short_reg", 8'h03, {5'h0, short_reg_out});
  endtask

  // Second request held during busy must wait for ready
  task automatic sc_refused;
    int n;
    present(8'h37, 8'h00, 1'b1);
    @(posedge clock_in);
    opcode_in <= 8'h2a;
    modrm_in  <= 8'h06;
    finish_exec(n);
    chk("busy_length", 8'h04, n[7:0]);
    chk("op_out", {4'h0, bcd_add_adjust}, {4'h0, op_out});
    take();
    finish_exec(n);
    chk("busy_length", 8'h06, n[7:0]);
    chk("op_out", {4'h0, op_subtract}, {4'h0, op_out});
  endtask

  // Three disabled cycles stretch the run; one enabled busy clock passes before them
  task automatic sc_freeze;
    int n;
    present(8'h2b, 8'h06, 1'b1);
    take();
    @(posedge clock_in);
    en_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    en_in <= 1'b1;
    finish_exec(n);
    chk("frozen_busy", 8'h05, n[7:0]);
    chk("done_out", 8'h01, {7'h0, done_out});
  endtask

  task automatic sc_reset_mid;
    present(8'h28, 8'h06, 1'b1);
    take();
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b0;
    @(negedge clock_in);
    chk("rst_busy", 8'h00, {7'h0, busy_out});
    chk("rst_ready", 8'h01, {7'h0, ready_out});
    chk("rst_op", {4'h0, op_none}, {4'h0, op_out});
    @(posedge clock_in);
    nrst_in <= 1'b1;
    run_case(8'h2f, 8'h00, packed_sub_adjust, 4);
  endtask

  initial
  begin
    clock_in    = 1'b0;
    nrst_in     = 1'b0;
    en_in       = 1'b1;
    valid_in    = 1'b0;
    opcode_in   = 8'h00;
    modrm_in    = 8'h00;
    opsize32_in = 1'b1;
    n_mismatch  = 0;
    checks_done = 0;
    repeat (20) @(posedge clock_in);
    nrst_in <= 1'b1;
    sc_subtract();
    sc_borrow();
    sc_dec_cmp_neg();
    sc_adjust();
    sc_reject();
    sc_fields();
    sc_refused();
    sc_freeze();
    sc_reset_mid();
    complete_run();
  end
endmodule
